// ===== core/epc_regs.sv
`timescale 1ns/1ps
module epc_regs (
	// System.
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Wishbone slave.
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Encoders, turns and full position (upper 16 bits: 65536 per turn).
	input  wire logic [15:0] fb_turns,
	input  wire logic [31:0] fb_pos,
	input  wire logic [15:0] ref_turns,
	input  wire logic [31:0] ref_pos,
	// Pins.
	input  wire logic        freeze_in,
	input  wire logic        fb_marker_in,
	input  wire logic        ref_marker_in,
	input  wire logic [2:0]  lcd_keys,
	input  wire logic [2:0]  led_keys,
	// Motion profile engine trip.
	input  wire logic        trip_valid,
	input  wire logic [7:0]  trip_code,
	input  wire logic [2:0]  trip_err_id,
	// Event tasks and source decode.
	output logic      [3:0]  evt_start,
	output logic      [5:0]  ref_src_onehot,
	output logic      [5:0]  fb_src_onehot,
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection.

	localparam int NSYNC = 9;
	logic [NSYNC-1:0] s1_r;
	logic [NSYNC-1:0] s2_r;
	logic [NSYNC-1:0] s3_r;
	wire  [NSYNC-1:0] pins = {lcd_keys, led_keys, ref_marker_in, fb_marker_in, freeze_in};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= pins;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	wire frz_rise   = s2_r[0] & ~s3_r[0];
	wire fb_mk_rise = s2_r[1] & ~s3_r[1];
	wire rf_mk_rise = s2_r[2] & ~s3_r[2];

	function automatic logic [31:0] pack_tp(input logic [15:0] t, input logic [31:0] p);
		pack_tp = {t, p[31:16]};
	endfunction

	function automatic logic [5:0] src_dec(input logic [7:0] v);
		src_dec = '0;
		if (v <= {5'h00, 3'(epc_pkg::EPC_SRC_UNCONF)})
			src_dec[v[2:0]] = 1'b1;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode.

	wire        req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        wr      = req & wb_we_i & wb_sel_i[0];
	wire        rd      = req & ~wb_we_i;
	wire        wr_zero = ~wb_dat_i[0];
	wire        w_evt   = wr & (wb_adr_i == epc_pkg::OFS_EVT_TRIG);
	wire        w_rsrc  = wr & (wb_adr_i == epc_pkg::OFS_REF_SRC);
	wire        w_fsrc  = wr & (wb_adr_i == epc_pkg::OFS_FB_SRC);
	wire        w_rmken = wr & (wb_adr_i == epc_pkg::OFS_REF_MK_EN);
	wire        w_fmken = wr & (wb_adr_i == epc_pkg::OFS_FB_MK_EN);
	wire        w_rfzen = wr & (wb_adr_i == epc_pkg::OFS_REF_FRZ_EN);
	wire        w_ffzen = wr & (wb_adr_i == epc_pkg::OFS_FB_FRZ_EN);
	wire        w_mask  = wr & (wb_adr_i == epc_pkg::OFS_IRQ_MASK);
	wire        clr_rmk = wr & wr_zero & (wb_adr_i == epc_pkg::OFS_REF_MK_FLAG);
	wire        clr_fmk = wr & wr_zero & (wb_adr_i == epc_pkg::OFS_FB_MK_FLAG);
	wire        clr_rfz = wr & wr_zero & (wb_adr_i == epc_pkg::OFS_REF_FRZ_FLG);
	wire        clr_ffz = wr & wr_zero & (wb_adr_i == epc_pkg::OFS_FB_FRZ_FLG);
	wire        r_stat  = rd & (wb_adr_i == epc_pkg::OFS_IRQ_STAT);

	////////////////////////////////////////////////////////////////////////////////
	// Control registers.

	logic [15:0] evt_r;
	logic [7:0]  rsrc_r;
	logic [7:0]  fsrc_r;
	logic        rmken_r;
	logic        fmken_r;
	logic        rfzen_r;
	logic        ffzen_r;
	logic [epc_pkg::IRQ_W-1:0] mask_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			evt_r   <= epc_pkg::EVT_RESET;
			rsrc_r  <= epc_pkg::SRC_RESET;
			fsrc_r  <= epc_pkg::SRC_RESET;
			rmken_r <= 1'b0;
			fmken_r <= 1'b0;
			rfzen_r <= 1'b0;
			ffzen_r <= 1'b0;
			mask_r  <= '0;
		end else begin
			if (w_evt && wb_sel_i[1])
				evt_r <= wb_dat_i[15:0];
			else if (w_evt)
				evt_r <= {evt_r[15:8], wb_dat_i[7:0]};
			if (w_rsrc)
				rsrc_r <= wb_dat_i[7:0];
			if (w_fsrc)
				fsrc_r <= wb_dat_i[7:0];
			if (w_rmken)
				rmken_r <= wb_dat_i[0];
			if (w_fmken)
				fmken_r <= wb_dat_i[0];
			if (w_rfzen)
				rfzen_r <= wb_dat_i[0];
			if (w_ffzen)
				ffzen_r <= wb_dat_i[0];
			if (w_mask)
				mask_r <= wb_dat_i[epc_pkg::IRQ_W-1:0];
		end
	end

	// A write of 1..4 starts base, first, second or third event task for one cycle.
	wire [15:0] evt_val = wb_sel_i[1] ? wb_dat_i[15:0] : {evt_r[15:8], wb_dat_i[7:0]};
	wire [3:0]  evt_nxt;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_evt
			assign evt_nxt[gi] = w_evt & (evt_val == 16'(gi + 1));
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Captures and flags.

	wire [31:0] fb_live  = pack_tp(fb_turns, fb_pos);
	wire [31:0] ref_live = pack_tp(ref_turns, ref_pos);

	logic [31:0] fb_live_r;
	logic [31:0] ref_live_r;
	logic [31:0] fb_frz_r;
	logic [31:0] ref_frz_r;
	logic [31:0] fb_frz_pos_r;
	logic [15:0] fb_frz_trn_r;
	logic [31:0] ref_frz_pos_r;
	logic [15:0] ref_frz_trn_r;
	logic [31:0] fb_mk_r;
	logic [31:0] ref_mk_r;
	logic [31:0] fb_mk_pos_r;
	logic [15:0] fb_mk_trn_r;
	logic [31:0] ref_mk_pos_r;
	logic [15:0] ref_mk_trn_r;
	logic        ffz_flag_r;
	logic        rfz_flag_r;
	logic        fmk_flag_r;
	logic        rmk_flag_r;
	logic [31:0] rt_err_r;
	logic [2:0]  keys_r;

	// Freeze captures only while the flag is clear; the enable gates only the flag and its interrupt status bit.
	wire ffz_cap = frz_rise & ~ffz_flag_r;
	wire rfz_cap = frz_rise & ~rfz_flag_r;
	wire ffz_set = ffz_cap & ffzen_r;
	wire rfz_set = rfz_cap & rfzen_r;
	wire fmk_set = fb_mk_rise & fmken_r;
	wire rmk_set = rf_mk_rise & rmken_r;
	wire rt_load = trip_valid & (trip_code == epc_pkg::RT_TRIP_CODE);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fb_live_r     <= '0;
			ref_live_r    <= '0;
			fb_frz_r      <= '0;
			ref_frz_r     <= '0;
			fb_frz_pos_r  <= '0;
			fb_frz_trn_r  <= '0;
			ref_frz_pos_r <= '0;
			ref_frz_trn_r <= '0;
			fb_mk_r       <= '0;
			ref_mk_r      <= '0;
			fb_mk_pos_r   <= '0;
			fb_mk_trn_r   <= '0;
			ref_mk_pos_r  <= '0;
			ref_mk_trn_r  <= '0;
			rt_err_r      <= '0;
			keys_r        <= '0;
		end else begin
			fb_live_r  <= fb_live;
			ref_live_r <= ref_live;
			keys_r     <= s2_r[5:3] | s2_r[8:6];
			if (ffz_cap) begin
				fb_frz_r     <= fb_live;
				fb_frz_pos_r <= fb_pos;
				fb_frz_trn_r <= fb_turns;
			end
			if (rfz_cap) begin
				ref_frz_r     <= ref_live;
				ref_frz_pos_r <= ref_pos;
				ref_frz_trn_r <= ref_turns;
			end
			if (fb_mk_rise && !fmk_flag_r) begin
				fb_mk_r     <= fb_live;
				fb_mk_pos_r <= fb_pos;
				fb_mk_trn_r <= fb_turns;
			end
			if (rf_mk_rise && !rmk_flag_r) begin
				ref_mk_r     <= ref_live;
				ref_mk_pos_r <= ref_pos;
				ref_mk_trn_r <= ref_turns;
			end
			if (rt_load)
				rt_err_r <= {29'h0000_0000, trip_err_id};
		end
	end

	// Hardware set wins over a software zero write; a write of 1 is ignored.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ffz_flag_r <= 1'b0;
			rfz_flag_r <= 1'b0;
			fmk_flag_r <= 1'b0;
			rmk_flag_r <= 1'b0;
		end else begin
			ffz_flag_r <= ffz_set | (ffz_flag_r & ~clr_ffz);
			rfz_flag_r <= rfz_set | (rfz_flag_r & ~clr_rfz);
			fmk_flag_r <= fmk_set | (fmk_flag_r & ~clr_fmk);
			rmk_flag_r <= rmk_set | (rmk_flag_r & ~clr_rmk);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupts: sticky status cleared by reading it.

	logic [epc_pkg::IRQ_W-1:0] stat_r;
	wire  [epc_pkg::IRQ_W-1:0] ev = {rt_load, rmk_set, fmk_set, rfz_set, ffz_set};
	wire  [epc_pkg::IRQ_W-1:0] stat_nxt = ev | (stat_r & {epc_pkg::IRQ_W{~r_stat}});

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_r <= '0;
			irq    <= 1'b0;
		end else begin
			stat_r <= stat_nxt;
			irq    <= |(stat_nxt & mask_r);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read mux and outputs.

	logic [31:0] rd_mux;
	always_comb begin
		unique case (wb_adr_i)
			epc_pkg::OFS_FB_LIVE:     rd_mux = fb_live_r;
			epc_pkg::OFS_REF_LIVE:    rd_mux = ref_live_r;
			epc_pkg::OFS_FB_FRZ:      rd_mux = fb_frz_r;
			epc_pkg::OFS_REF_FRZ:     rd_mux = ref_frz_r;
			epc_pkg::OFS_REF_MK_POS:  rd_mux = ref_mk_pos_r;
			epc_pkg::OFS_REF_MK_TRN:  rd_mux = {16'h0000, ref_mk_trn_r};
			epc_pkg::OFS_FB_MK:       rd_mux = fb_mk_r;
			epc_pkg::OFS_REF_MK:      rd_mux = ref_mk_r;
			epc_pkg::OFS_KEYPAD:      rd_mux = {29'h0000_0000, keys_r};
			epc_pkg::OFS_EVT_TRIG:    rd_mux = {16'h0000, evt_r};
			epc_pkg::OFS_REF_MK_FLAG: rd_mux = {31'h0000_0000, rmk_flag_r};
			epc_pkg::OFS_FB_MK_FLAG:  rd_mux = {31'h0000_0000, fmk_flag_r};
			epc_pkg::OFS_REF_SRC:     rd_mux = {24'h00_0000, rsrc_r};
			epc_pkg::OFS_FB_SRC:      rd_mux = {24'h00_0000, fsrc_r};
			epc_pkg::OFS_REF_MK_EN:   rd_mux = {31'h0000_0000, rmken_r};
			epc_pkg::OFS_FB_MK_EN:    rd_mux = {31'h0000_0000, fmken_r};
			epc_pkg::OFS_REF_FRZ_EN:  rd_mux = {31'h0000_0000, rfzen_r};
			epc_pkg::OFS_FB_FRZ_EN:   rd_mux = {31'h0000_0000, ffzen_r};
			epc_pkg::OFS_RT_ERR:      rd_mux = rt_err_r;
			epc_pkg::OFS_REF_FRZ_FLG: rd_mux = {31'h0000_0000, rfz_flag_r};
			epc_pkg::OFS_FB_FRZ_FLG:  rd_mux = {31'h0000_0000, ffz_flag_r};
			epc_pkg::OFS_FB_FRZ_POS:  rd_mux = fb_frz_pos_r;
			epc_pkg::OFS_FB_FRZ_TRN:  rd_mux = {16'h0000, fb_frz_trn_r};
			epc_pkg::OFS_REF_FRZ_POS: rd_mux = ref_frz_pos_r;
			epc_pkg::OFS_REF_FRZ_TRN: rd_mux = {16'h0000, ref_frz_trn_r};
			epc_pkg::OFS_FB_MK_POS:   rd_mux = fb_mk_pos_r;
			epc_pkg::OFS_FB_MK_TRN:   rd_mux = {16'h0000, fb_mk_trn_r};
			epc_pkg::OFS_IRQ_STAT:    rd_mux = {27'h000_0000, stat_r};
			epc_pkg::OFS_IRQ_MASK:    rd_mux = {27'h000_0000, mask_r};
			default:                  rd_mux = epc_pkg::UNMAPPED_VAL;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o       <= 1'b0;
			wb_dat_o       <= '0;
			evt_start      <= '0;
			ref_src_onehot <= '0;
			fb_src_onehot  <= '0;
		end else begin
			wb_ack_o       <= req;
			wb_dat_o       <= rd ? rd_mux : '0;
			evt_start      <= evt_nxt;
			ref_src_onehot <= src_dec(rsrc_r);
			fb_src_onehot  <= src_dec(fsrc_r);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.

	sequence s_mk_pulse;
		rf_mk_rise && rmken_r;
	endsequence

	a_ref_mk_flag: assert property (@(posedge clk) disable iff (!rst_n)
		s_mk_pulse |=> rmk_flag_r) else $error("reference marker flag not set");
	a_fb_mk_gate: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(fmk_flag_r) |-> $past(fb_mk_rise && fmken_r)) else $error("marker flag set unenabled");
	a_flag_no_one: assert property (@(posedge clk) disable iff (!rst_n)
		!rmk_flag_r && !rmk_set |=> !rmk_flag_r) else $error("marker flag set by software");
	a_frz_flag_gate: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(ffz_flag_r) |-> $past(frz_rise && ffzen_r)) else $error("freeze flag set unenabled");
	a_frz_hold: assert property (@(posedge clk) disable iff (!rst_n)
		ffz_flag_r && !clr_ffz |=> $stable(fb_frz_r)) else $error("freeze word changed while flagged");
	a_frz_word: assert property (@(posedge clk) disable iff (!rst_n)
		ffz_cap |=> fb_frz_r == $past(fb_live)) else $error("freeze word wrong");
	a_mk_turns: assert property (@(posedge clk) disable iff (!rst_n)
		rf_mk_rise && !rmk_flag_r |=> ref_mk_trn_r == $past(ref_turns)) else $error("marker turns wrong");
	a_mk_together: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(ref_mk_pos_r) |-> $changed(ref_mk_r) || $past(ref_live) == ref_mk_r)
		else $error("partial marker capture");
	a_evt_start: assert property (@(posedge clk) disable iff (!rst_n)
		w_evt && evt_val == 16'h0003 |=> evt_start == 4'h4 ##1 evt_start == 4'h0)
		else $error("event start wrong");
	a_rt_load: assert property (@(posedge clk) disable iff (!rst_n)
		rt_load |=> rt_err_r == {29'h0000_0000, $past(trip_err_id)}) else $error("error id not loaded");
	a_src_dec: assert property (@(posedge clk) disable iff (!rst_n)
		$stable(rsrc_r) && rsrc_r == 8'h04 |=> ref_src_onehot == 6'h10) else $error("source decode");
	// The live check starts one edge after release so the reset value is never compared.
	a_live_pack: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n |=> fb_live_r == {$past(fb_turns), $past(fb_pos[31:16])}) else $error("live word wrong");
	a_ref_live_pack: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n |=> ref_live_r == {$past(ref_turns), $past(ref_pos[31:16])}) else $error("ref live wrong");
	a_frz_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
		frz_rise && !ffz_flag_r && ffzen_r |=> ffz_flag_r) else $error("freeze flag not set");
	a_mk_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
		clr_rmk && !rmk_set |=> !rmk_flag_r) else $error("marker flag not cleared");

endmodule

// ===== inc/epc_pkg.sv
package epc_pkg;

	// Register byte offsets on the classic Wishbone slave.
	localparam logic [7:0] OFS_FB_LIVE     = 8'h00;
	localparam logic [7:0] OFS_REF_LIVE    = 8'h04;
	localparam logic [7:0] OFS_FB_FRZ      = 8'h08;
	localparam logic [7:0] OFS_REF_FRZ     = 8'h0C;
	localparam logic [7:0] OFS_REF_MK_POS  = 8'h10;
	localparam logic [7:0] OFS_REF_MK_TRN  = 8'h14;
	localparam logic [7:0] OFS_FB_MK       = 8'h18;
	localparam logic [7:0] OFS_REF_MK      = 8'h1C;
	localparam logic [7:0] OFS_KEYPAD      = 8'h20;
	localparam logic [7:0] OFS_EVT_TRIG    = 8'h24;
	localparam logic [7:0] OFS_REF_MK_FLAG = 8'h28;
	localparam logic [7:0] OFS_FB_MK_FLAG  = 8'h2C;
	localparam logic [7:0] OFS_REF_SRC     = 8'h30;
	localparam logic [7:0] OFS_FB_SRC      = 8'h34;
	localparam logic [7:0] OFS_REF_MK_EN   = 8'h38;
	localparam logic [7:0] OFS_FB_MK_EN    = 8'h3C;
	localparam logic [7:0] OFS_REF_FRZ_EN  = 8'h40;
	localparam logic [7:0] OFS_FB_FRZ_EN   = 8'h44;
	localparam logic [7:0] OFS_RT_ERR      = 8'h48;
	localparam logic [7:0] OFS_REF_FRZ_FLG = 8'h4C;
	localparam logic [7:0] OFS_FB_FRZ_FLG  = 8'h50;
	localparam logic [7:0] OFS_FB_FRZ_POS  = 8'h54;
	localparam logic [7:0] OFS_FB_FRZ_TRN  = 8'h58;
	localparam logic [7:0] OFS_REF_FRZ_POS = 8'h5C;
	localparam logic [7:0] OFS_REF_FRZ_TRN = 8'h60;
	localparam logic [7:0] OFS_FB_MK_POS   = 8'h64;
	localparam logic [7:0] OFS_FB_MK_TRN   = 8'h68;
	localparam logic [7:0] OFS_IRQ_STAT    = 8'h6C;
	localparam logic [7:0] OFS_IRQ_MASK    = 8'h70;

	// Keypad bit positions.
	localparam int KEY_REV  = 0;
	localparam int KEY_RUN  = 1;
	localparam int KEY_STOP = 2;

	// Interrupt status bit positions.
	localparam int IRQ_FB_FRZ  = 0;
	localparam int IRQ_REF_FRZ = 1;
	localparam int IRQ_FB_MK   = 2;
	localparam int IRQ_REF_MK  = 3;
	localparam int IRQ_RT_ERR  = 4;
	localparam int IRQ_W       = 5;

	localparam logic [7:0]  RT_TRIP_CODE = 8'h51;
	localparam logic [7:0]  SRC_RESET    = 8'h05;
	localparam logic [15:0] EVT_RESET    = 16'h0000;
	localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;

	typedef enum logic [2:0] {
		EPC_EVT_NONE   = 3'h0,
		EPC_EVT_BASE   = 3'h1,
		EPC_EVT_FIRST  = 3'h2,
		EPC_EVT_SECOND = 3'h3,
		EPC_EVT_THIRD  = 3'h4
	} epc_evt_t;

	typedef enum logic [2:0] {
		EPC_SRC_DRIVE  = 3'h0,
		EPC_SRC_SLOT1  = 3'h1,
		EPC_SRC_SLOT2  = 3'h2,
		EPC_SRC_SLOT3  = 3'h3,
		EPC_SRC_USER   = 3'h4,
		EPC_SRC_UNCONF = 3'h5
	} epc_src_t;

	typedef enum logic [2:0] {
		EPC_RT_NONE     = 3'h0,
		EPC_RT_CAM_SMALL = 3'h1,
		EPC_RT_OVERRUN  = 3'h2,
		EPC_RT_ZERO     = 3'h3,
		EPC_RT_ABS_RST  = 3'h4
	} epc_rt_t;

endpackage

// ===== dv/epc_enc_model.sv
`timescale 1ns/1ps
module epc_enc_model (
	// System.
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Control from the bench.
	input  wire logic        run,
	input  wire logic [2:0]  pulse_req,
	// Encoders.
	output logic      [15:0] fb_turns,
	output logic      [31:0] fb_pos,
	output logic      [15:0] ref_turns,
	output logic      [31:0] ref_pos,
	// Freeze and marker pins.
	output logic             freeze_in,
	output logic             fb_marker_in,
	output logic             ref_marker_in
);
	logic [2:0]  cnt_r [3];
	logic [32:0] fb_sum;
	logic [32:0] ref_sum;

	// A carry out of the position word is one turn of 65536 upper counts.
	assign fb_sum  = {1'b0, fb_pos} + 33'h0_0300_0101;
	assign ref_sum = {1'b0, ref_pos} + 33'h0_1100_0007;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fb_pos <= 32'hFF00_0010;
			fb_turns <= 16'h7FFE;
			ref_pos <= 32'hF000_0000;
			ref_turns <= 16'hFFFF;
		end else if (run) begin
			fb_pos <= fb_sum[31:0];
			fb_turns <= fb_turns + {15'h0000, fb_sum[32]};
			ref_pos <= ref_sum[31:0];
			ref_turns <= ref_turns + {15'h0000, ref_sum[32]};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Each pin stays high four cycles so the synchroniser cannot miss it.
	always_ff @(posedge clk or negedge rst_n) begin
		for (int i = 0; i < 3; i++) begin
			if (!rst_n)
				cnt_r[i] <= 3'h0;
			else if (pulse_req[i])
				cnt_r[i] <= 3'h4;
			else if (cnt_r[i] != 3'h0)
				cnt_r[i] <= cnt_r[i] - 3'h1;
		end
	end

	assign freeze_in     = cnt_r[0] != 3'h0;
	assign fb_marker_in  = cnt_r[1] != 3'h0;
	assign ref_marker_in = cnt_r[2] != 3'h0;
endmodule

// ===== dv/epc_regs_test.sv
`timescale 1ns/1ps
module epc_regs_test;
	logic        clk, rst_n, cyc, stb, we, ack, run, frz, fbm, refm, trip_v, irq;
	logic [7:0]  adr, trip_c;
	logic [3:0]  sel, evt, seen;
	logic [31:0] dat_i, dat_o, q, old;
	logic [15:0] fb_turns, ref_turns, sft, srt;
	logic [31:0] fb_pos, ref_pos, sfp, srp;
	logic [2:0]  lcd, led, trip_id, preq;
	logic [5:0]  ref_oh, fb_oh;
	int          fail_count, samples_checked, cnt;

	epc_regs i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.fb_turns(fb_turns), .fb_pos(fb_pos), .ref_turns(ref_turns), .ref_pos(ref_pos),
		.freeze_in(frz), .fb_marker_in(fbm), .ref_marker_in(refm), .lcd_keys(lcd),
		.led_keys(led), .trip_valid(trip_v), .trip_code(trip_c), .trip_err_id(trip_id),
		.evt_start(evt), .ref_src_onehot(ref_oh), .fb_src_onehot(fb_oh), .irq(irq));

	epc_enc_model i_enc (.clk(clk), .rst_n(rst_n), .run(run), .pulse_req(preq),
		.fb_turns(fb_turns), .fb_pos(fb_pos), .ref_turns(ref_turns), .ref_pos(ref_pos),
		.freeze_in(frz), .fb_marker_in(fbm), .ref_marker_in(refm));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		if (fail_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_i <= d;
		sel <= s;
		do @(posedge clk); while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000, 4'hF);
		chk(q, exp);
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic pulse(input logic [2:0] m);
		preq <= m;
		@(posedge clk);
		preq <= 3'h0;
		cycles(10);
	endtask

	task automatic snap(input int n);
		run <= 1'b1;
		cycles(n);
		run <= 1'b0;
		cycles(2);
		sft = fb_turns;
		sfp = fb_pos;
		srt = ref_turns;
		srp = ref_pos;
	endtask

	task automatic trip(input logic [7:0] c, input logic [2:0] id);
		trip_v <= 1'b1;
		trip_c <= c;
		trip_id <= id;
		@(posedge clk);
		trip_v <= 1'b0;
		cycles(3);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, cyc, stb, we, run, trip_v} = 6'h00;
		{adr, trip_c, sel, dat_i, lcd, led, trip_id, preq} = '0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		cycles(2);
		chk({26'h0, ref_oh}, 32'h20);
		rd(epc_pkg::OFS_REF_SRC, 32'h5);
		rd(epc_pkg::OFS_EVT_TRIG, 32'h0);
		rd(8'h7C, 32'h0);
		for (int v = 0; v < 7; v++) begin
			wr(epc_pkg::OFS_REF_SRC, v);
			wr(epc_pkg::OFS_FB_SRC, v);
			@(posedge clk);
			chk({26'h0, ref_oh}, (v < 6) ? (32'h1 << v) : 32'h0);
			chk({26'h0, fb_oh}, (v < 6) ? (32'h1 << v) : 32'h0);
		end
		wr(epc_pkg::OFS_REF_SRC, 32'h3);
		bus(1'b1, epc_pkg::OFS_REF_SRC, 32'h1, 4'hE);
		rd(epc_pkg::OFS_REF_SRC, 32'h3);
		for (int v = 0; v < 5; v++) begin
			seen = 4'h0;
			cnt = 0;
			// The start pulse stands in the ack cycle, so it is watched during the write.
			fork
				wr(epc_pkg::OFS_EVT_TRIG, v);
				repeat (6) begin
					@(posedge clk);
					seen |= evt;
					cnt += (evt != 4'h0);
				end
			join
			chk(seen, (v == 0) ? 32'h0 : (32'h1 << (v - 1)));
			chk(cnt, (v != 0));
			rd(epc_pkg::OFS_EVT_TRIG, v);
		end
		for (int k = 0; k < 8; k++) begin
			lcd <= 3'(k);
			led <= 3'h0;
			cycles(4);
			rd(epc_pkg::OFS_KEYPAD, k);
			lcd <= 3'h0;
			led <= 3'(k);
			cycles(4);
			rd(epc_pkg::OFS_KEYPAD, k);
		end
		snap(60);
		rd(epc_pkg::OFS_FB_LIVE, {sft, sfp[31:16]});
		rd(epc_pkg::OFS_REF_LIVE, {srt, srp[31:16]});
		wr(epc_pkg::OFS_FB_FRZ_EN, 32'h1);
		pulse(3'b001);
		chk(irq, 1'b0);
		old = {sft, sfp[31:16]};
		rd(epc_pkg::OFS_FB_FRZ, old);
		rd(epc_pkg::OFS_REF_FRZ, {srt, srp[31:16]});
		rd(epc_pkg::OFS_FB_FRZ_POS, sfp);
		rd(epc_pkg::OFS_FB_FRZ_TRN, sft);
		rd(epc_pkg::OFS_FB_FRZ_FLG, 32'h1);
		rd(epc_pkg::OFS_REF_FRZ_FLG, 32'h0);
		wr(epc_pkg::OFS_IRQ_MASK, 32'h1F);
		cycles(2);
		chk(irq, 1'b1);
		bus(1'b0, epc_pkg::OFS_IRQ_STAT, 32'h0, 4'hF);
		chk(q & 32'h1, 32'h1);
		cycles(2);
		chk(irq, 1'b0);
		snap(20);
		pulse(3'b001);
		rd(epc_pkg::OFS_FB_FRZ, old);
		wr(epc_pkg::OFS_FB_FRZ_FLG, 32'h0);
		pulse(3'b001);
		rd(epc_pkg::OFS_FB_FRZ, {sft, sfp[31:16]});
		wr(epc_pkg::OFS_REF_MK_EN, 32'h1);
		snap(30);
		bus(1'b0, epc_pkg::OFS_IRQ_STAT, 32'h0, 4'hF);
		cycles(2);
		chk(irq, 1'b0);
		pulse(3'b110);
		chk(irq, 1'b1);
		rd(epc_pkg::OFS_IRQ_STAT, 32'h8);
		rd(epc_pkg::OFS_REF_MK_POS, srp);
		rd(epc_pkg::OFS_REF_MK_TRN, {16'h0, srt});
		rd(epc_pkg::OFS_REF_MK, {srt, srp[31:16]});
		rd(epc_pkg::OFS_FB_MK, {sft, sfp[31:16]});
		rd(epc_pkg::OFS_FB_MK_POS, sfp);
		rd(epc_pkg::OFS_REF_MK_FLAG, 32'h1);
		rd(epc_pkg::OFS_FB_MK_FLAG, 32'h0);
		wr(epc_pkg::OFS_FB_MK_FLAG, 32'h1);
		rd(epc_pkg::OFS_FB_MK_FLAG, 32'h0);
		wr(epc_pkg::OFS_REF_MK_FLAG, 32'h0);
		rd(epc_pkg::OFS_REF_MK_FLAG, 32'h0);
		wr(epc_pkg::OFS_FB_MK_EN, 32'h1);
		pulse(3'b010);
		rd(epc_pkg::OFS_FB_MK_FLAG, 32'h1);
		rd(epc_pkg::OFS_REF_MK_FLAG, 32'h0);
		for (int id = 4; id >= 0; id--) begin
			trip(epc_pkg::RT_TRIP_CODE, 3'(id));
			rd(epc_pkg::OFS_RT_ERR, id);
		end
		trip(8'h50, 3'h2);
		rd(epc_pkg::OFS_RT_ERR, 32'h0);
		finish_test();
	end

	// The whole sequence needs fewer than a thousand cycles; this limit of 40000 cycles is far beyond it.
	initial begin
		#200000;
		fail_count++;
		finish_test();
	end
endmodule
